// >>> byte_fifo.v
`timescale 1ns/100ps
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             clk_sys,
    input  wire             arst_n,
    input  wire [WIDTH-1:0] inData,
    input  wire             inValid,
    output wire             inReady,
    output wire [WIDTH-1:0] outData,
    output wire             outValid,
    input  wire             outReady
);
    localparam [AW:0] DEPTH_C = DEPTH;

    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wrPtr_ff;
    reg  [AW-1:0]    rdPtr_ff;
    reg  [AW:0]      count_ff;
    reg              inReady_ff;
    reg              outValid_ff;
    reg  [WIDTH-1:0] outData_ff;
    wire             push;
    wire             load;
    wire [AW:0]      nxt_count;

    assign push      = inValid & inReady_ff;
    // the output register refills from memory whenever memory holds a byte and the register is empty or being taken
    assign load      = (count_ff != {(AW+1){1'b0}}) & (~outValid_ff | outReady);
    assign nxt_count = count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    assign inReady   = inReady_ff;
    assign outValid  = outValid_ff;
    assign outData   = outData_ff;

    always @(posedge clk_sys) begin
        if (push) begin
            mem[wrPtr_ff] <= inData;
        end
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wrPtr_ff    <= {AW{1'b0}};
            rdPtr_ff    <= {AW{1'b0}};
            count_ff    <= {(AW+1){1'b0}};
            inReady_ff  <= 1'b1;
            outValid_ff <= 1'b0;
            outData_ff  <= {WIDTH{1'b0}};
        end else begin
            count_ff   <= nxt_count;
            inReady_ff <= (nxt_count != DEPTH_C);
            if (push) begin
                wrPtr_ff <= wrPtr_ff + 1'b1;
            end
            if (load) begin
                rdPtr_ff    <= rdPtr_ff + 1'b1;
                outData_ff  <= mem[rdPtr_ff];
                outValid_ff <= 1'b1;
            end else if (outReady) begin
                outValid_ff <= 1'b0;
            end
        end
    end
endmodule // byte_fifo

// >>> cmd_frame_interp.v
// Contract
// - listen by default, drive bus only replying
// - never transmit before a command arrives
// - exactly one reply per executed command
// - command core is seven bytes
// - serial frame adds address and checksum
// - serial byte order, value MSB first
// - command checksum is 8-bit sum, verified
// - CAN frames carry no address, checksum
// - serial reply byte order, value MSB first
// - reply checksum is 8-bit sum
// - CAN reply omits address and checksum
// - status 100 done, 101 stored
// - error status codes one to six
`timescale 1ns/100ps
`include "cmd_frame_regs.vh"
module cmd_frame_interp #(
    parameter FIFO_DEPTH = `CF_FIFO_DEPTH,
    parameter FIFO_AW    = `CF_FIFO_AW
) (
    input  wire        clk_sys,
    input  wire        arst_n,
    input  wire        canMode,
    input  wire [7:0]  moduleAddr,
    input  wire [7:0]  replyAddr,
    input  wire [7:0]  rxData,
    input  wire        rxValid,
    output wire        rxReady,
    output reg         cmdValid_ff,
    output reg  [7:0]  cmdCode_ff,
    output reg  [7:0]  cmdType_ff,
    output reg  [7:0]  cmdMotor_ff,
    output reg  [31:0] cmdValue_ff,
    input  wire        execDone,
    input  wire [7:0]  execStatus,
    input  wire [31:0] execValue,
    output reg  [7:0]  txData_ff,
    output reg         txValid_ff,
    input  wire        txReady,
    output reg         txFirst_ff,
    output reg         txLast_ff,
    output reg  [7:0]  txCanId_ff,
    output reg         busDriveEn_ff,
    output reg         frameDropped_ff,
    output reg         checksumError_ff
);
    localparam [1:0] ST_COLLECT = 2'h0;
    localparam [1:0] ST_EXEC    = 2'h1;
    localparam [1:0] ST_REPLY   = 2'h2;

    localparam [3:0] CMD_LAST_SERIAL   = `CF_SERIAL_CMD_LEN - 4'h1;
    localparam [3:0] REPLY_LAST_SERIAL = `CF_SERIAL_REPLY_LEN - 4'h1;
    localparam [3:0] REPLY_LAST_CAN    = `CF_CAN_REPLY_LEN - 4'h1;

    reg  [1:0]  state_ff;
    reg  [3:0]  rxIdx_ff;
    reg         frameCan_ff;
    reg  [7:0]  rxSum_ff;
    reg  [7:0]  rxAddr_ff;
    reg  [7:0]  rplStatus_ff;
    reg  [31:0] rplValue_ff;
    reg  [7:0]  txSum_ff;
    reg  [3:0]  txIdx_ff;
    wire [7:0]  fifoData;
    wire        fifoValid;
    wire        fifoReady;
    wire        popByte;
    wire        isCan;
    wire [3:0]  rxPos;
    wire [3:0]  txPos;
    wire        rxLastByte;
    wire [7:0]  nxt_rxSum;

    // map a byte index to its serial position, skipping the bytes absent on CAN
    function [3:0] serialPos;
        input [3:0] idx;
        input       can;
        input [3:0] skip;
        begin
            serialPos = can ? idx + skip : idx;
        end
    endfunction

    function [7:0] replyByte;
        input [3:0]  pos;
        input [7:0]  rAddr;
        input [7:0]  mAddr;
        input [7:0]  status;
        input [7:0]  code;
        input [31:0] value;
        input [7:0]  sum;
        begin
            case (pos)
                `CF_RPOS_REPLY_ADDR:  replyByte = rAddr;
                `CF_RPOS_MODULE_ADDR: replyByte = mAddr;
                `CF_RPOS_STATUS:      replyByte = status;
                `CF_RPOS_CODE:        replyByte = code;
                4'h4:                 replyByte = value[31:24];
                4'h5:                 replyByte = value[23:16];
                4'h6:                 replyByte = value[15:8];
                `CF_RPOS_VALUE_LSB:   replyByte = value[7:0];
                `CF_RPOS_CHECKSUM:    replyByte = sum;
                default:              replyByte = 8'h00;
            endcase
        end
    endfunction

    // incoming bytes wait here while a command executes or a reply goes out
    byte_fifo #(
        .WIDTH (`CF_FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_rx_fifo (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .inData   (rxData),
        .inValid  (rxValid),
        .inReady  (rxReady),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (fifoReady)
    );

    // only drained while collecting, so the host stalls if it runs ahead
    assign fifoReady = (state_ff == ST_COLLECT);
    assign popByte   = fifoValid & fifoReady;
    // frame kind is fixed at its first byte
    assign isCan     = (rxIdx_ff == 4'h0) ? canMode : frameCan_ff;
    assign rxPos     = serialPos(rxIdx_ff, isCan, `CF_CAN_CMD_SKIP);
    assign rxLastByte = isCan ? (rxPos == `CF_POS_VALUE_LSB) : (rxPos == CMD_LAST_SERIAL);
    assign nxt_rxSum = rxSum_ff + fifoData;
    assign txPos     = serialPos(txIdx_ff, frameCan_ff, `CF_CAN_REPLY_SKIP);

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_ff         <= ST_COLLECT;
            rxIdx_ff         <= 4'h0;
            frameCan_ff      <= 1'b0;
            rxSum_ff         <= 8'h00;
            rxAddr_ff        <= 8'h00;
            rplStatus_ff     <= 8'h00;
            rplValue_ff      <= 32'h00000000;
            txSum_ff         <= 8'h00;
            txIdx_ff         <= 4'h0;
            cmdValid_ff      <= 1'b0;
            cmdCode_ff       <= 8'h00;
            cmdType_ff       <= 8'h00;
            cmdMotor_ff      <= 8'h00;
            cmdValue_ff      <= 32'h00000000;
            txData_ff        <= 8'h00;
            txValid_ff       <= 1'b0;
            txFirst_ff       <= 1'b0;
            txLast_ff        <= 1'b0;
            txCanId_ff       <= 8'h00;
            busDriveEn_ff    <= 1'b0;
            frameDropped_ff  <= 1'b0;
            checksumError_ff <= 1'b0;
        end else begin
            cmdValid_ff      <= 1'b0;
            frameDropped_ff  <= 1'b0;
            checksumError_ff <= 1'b0;
            case (state_ff)
                ST_COLLECT: begin
                    busDriveEn_ff <= 1'b0;
                    txValid_ff    <= 1'b0;
                    if (popByte) begin
                        if (rxIdx_ff == 4'h0) begin
                            frameCan_ff <= canMode;
                        end
                        if (rxPos != `CF_POS_CHECKSUM) begin
                            rxSum_ff <= nxt_rxSum;
                        end
                        case (rxPos)
                            `CF_POS_ADDR:  rxAddr_ff   <= fifoData;
                            `CF_POS_CODE:  cmdCode_ff  <= fifoData;
                            `CF_POS_TYPE:  cmdType_ff  <= fifoData;
                            `CF_POS_MOTOR: cmdMotor_ff <= fifoData;
                            `CF_POS_CHECKSUM: begin
                            end
                            default:       cmdValue_ff <= {cmdValue_ff[23:0], fifoData};
                        endcase
                        if (!rxLastByte) begin
                            rxIdx_ff <= rxIdx_ff + 4'h1;
                        end else begin
                            rxIdx_ff <= 4'h0;
                            rxSum_ff <= 8'h00;
                            if (isCan) begin
                                cmdValid_ff <= 1'b1;
                                state_ff    <= ST_EXEC;
                            end else if (rxAddr_ff != moduleAddr) begin
                                frameDropped_ff <= 1'b1;
                            end else if (rxSum_ff != fifoData) begin
                                checksumError_ff <= 1'b1;
                                rplStatus_ff     <= `CF_ST_BAD_CHECKSUM;
                                rplValue_ff      <= 32'h00000000;
                                txIdx_ff         <= 4'h0;
                                txSum_ff         <= 8'h00;
                                txCanId_ff       <= replyAddr;
                                state_ff         <= ST_REPLY;
                            end else begin
                                cmdValid_ff <= 1'b1;
                                state_ff    <= ST_EXEC;
                            end
                        end
                    end
                end
                ST_EXEC: begin
                    // executor supplies 100, 101 or one of the error codes
                    if (execDone) begin
                        rplStatus_ff <= execStatus;
                        rplValue_ff  <= execValue;
                        txIdx_ff     <= 4'h0;
                        txSum_ff     <= 8'h00;
                        txCanId_ff   <= replyAddr;
                        state_ff     <= ST_REPLY;
                    end
                end
                ST_REPLY: begin
                    busDriveEn_ff <= 1'b1;
                    if (!txValid_ff || txReady) begin
                        if (txIdx_ff <= (frameCan_ff ? REPLY_LAST_CAN : REPLY_LAST_SERIAL)) begin
                            txData_ff  <= replyByte(txPos, replyAddr, moduleAddr, rplStatus_ff,
                                                    cmdCode_ff, rplValue_ff, txSum_ff);
                            txSum_ff   <= txSum_ff + replyByte(txPos, replyAddr, moduleAddr, rplStatus_ff,
                                                               cmdCode_ff, rplValue_ff, txSum_ff);
                            txValid_ff <= 1'b1;
                            txFirst_ff <= (txIdx_ff == 4'h0);
                            txLast_ff  <= (txIdx_ff == (frameCan_ff ? REPLY_LAST_CAN : REPLY_LAST_SERIAL));
                            txIdx_ff   <= txIdx_ff + 4'h1;
                        end else begin
                            // last byte taken: give the bus back
                            txValid_ff    <= 1'b0;
                            txFirst_ff    <= 1'b0;
                            txLast_ff     <= 1'b0;
                            busDriveEn_ff <= 1'b0;
                            state_ff      <= ST_COLLECT;
                        end
                    end
                end
                default: begin
                    state_ff <= ST_COLLECT;
                end
            endcase
        end
    end
endmodule // cmd_frame_interp

// >>> cmd_frame_interp_bench.sv
`timescale 1ns/100ps
module cmd_frame_interp_bench;
    logic clk_sys = 0, arst_n = 0, canMode = 0, execDone = 0;
    logic [7:0] moduleAddr = 8'h2A, replyAddr = 8'h02, execStatus = 8'h00;
    logic [31:0] execValue = 32'h0;
    wire logic [7:0] rxData, txData_ff, cmdCode_ff, cmdType_ff, cmdMotor_ff, txCanId_ff;
    wire logic [31:0] cmdValue_ff;
    wire logic rxValid, rxReady, cmdValid_ff, txValid_ff, txReady, txFirst_ff, txLast_ff;
    wire logic busDriveEn_ff, frameDropped_ff, checksumError_ff;
    int err_count = 0, tests_run = 0, cyc = 0, nCmd = 0, nDrop = 0, nBad = 0;
    cmd_frame_interp dut (.clk_sys, .arst_n, .canMode, .moduleAddr, .replyAddr, .rxData, .rxValid, .rxReady,
        .cmdValid_ff, .cmdCode_ff, .cmdType_ff, .cmdMotor_ff, .cmdValue_ff, .execDone, .execStatus, .execValue,
        .txData_ff, .txValid_ff, .txReady, .txFirst_ff, .txLast_ff, .txCanId_ff, .busDriveEn_ff,
        .frameDropped_ff, .checksumError_ff);
    host_model host (.clk_sys, .rxReady, .rxData, .rxValid, .txData_ff, .txValid_ff, .txReady);
    initial forever #50 clk_sys = ~clk_sys;
    task results;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        nCmd += cmdValid_ff;
        nDrop += frameDropped_ff;
        nBad += checksumError_ff;
        if (cyc == 20000) begin
            err_count++;
            results;
        end
    end
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task send(input logic [7:0] a, c, t, m, input logic [31:0] v, input logic [7:0] sumOfs);
        logic [7:0] q[$];
        q = {c, t, m, v[31:24], v[23:16], v[15:8], v[7:0]};
        if (!canMode) begin
            q.push_front(a);
            q.push_back(a + c + t + m + v[31:24] + v[23:16] + v[15:8] + v[7:0] + sumOfs);
        end
        host.sendFrame(q);
    endtask
    task exec(input logic [7:0] st, input logic [31:0] v);
        int i;
        i = 0;
        while (cmdValid_ff !== 1'b1 && i < 200) begin
            @(posedge clk_sys);
            i++;
        end
        execStatus <= st;
        execValue <= v;
        execDone <= 1'b1;
        @(posedge clk_sys);
        execDone <= 1'b0;
    endtask
    task expectReply(input logic [7:0] st, c, input logic [31:0] v);
        logic [7:0] e[$];
        int i;
        e = {st, c, v[31:24], v[23:16], v[15:8], v[7:0]};
        if (!canMode) begin
            e.push_front(moduleAddr);
            e.push_front(replyAddr);
            e.push_back(8'h00);
            foreach (e[k]) if (k < 8) e[8] += e[k];
        end
        i = 0;
        while (host.got.size() < e.size() && i < 300) begin
            @(posedge clk_sys);
            i++;
        end
        repeat (4) @(posedge clk_sys);
        chk(host.got.size(), e.size());
        foreach (e[k]) chk(host.got[k], e[k]);
        host.got.delete();
    endtask
    task t_codes;
        logic [7:0] sts[7] = '{8'h64, 8'h65, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};
        for (int i = 0; i < 7; i++) begin
            host.slow = i[0];
            send(moduleAddr, 8'(i + 1), 8'hA5, 8'h01, 32'h80C1E2F3 + i, 8'h00);
            exec(sts[i], 32'hFEDC0010 + i);
            chk({cmdCode_ff, cmdType_ff, cmdMotor_ff}, {8'(i + 1), 8'hA5, 8'h01});
            chk(cmdValue_ff, 32'h80C1E2F3 + i);
            expectReply(sts[i], 8'(i + 1), 32'hFEDC0010 + i);
        end
        host.slow = 1'b0;
    endtask
    task t_badsum;
        int c0;
        c0 = nCmd;
        send(moduleAddr, 8'h05, 8'h04, 8'h00, 32'h00000123, 8'h01);
        expectReply(8'h01, 8'h05, 32'h0);
        chk(nCmd - c0, 0);
        chk(nBad, 1);
    endtask
    task t_foreign;
        send(8'h2B, 8'h01, 8'h00, 8'h00, 32'h00000010, 8'h00);
        repeat (60) @(posedge clk_sys);
        chk(nDrop, 1);
        chk(host.got.size(), 0);
    endtask
    task t_can;
        canMode <= 1'b1;
        @(posedge clk_sys);
        send(8'h00, 8'h06, 8'h07, 8'h02, 32'h01020304, 8'h00);
        exec(8'h64, 32'h0A0B0C0D);
        chk(cmdValue_ff, 32'h01020304);
        expectReply(8'h64, 8'h06, 32'h0A0B0C0D);
        chk(txCanId_ff, replyAddr);
        canMode <= 1'b0;
        @(posedge clk_sys);
    endtask
    task t_fifo;
        logic [7:0] f[9] = '{8'h33, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h34};
        logic [7:0] rest[$];
        int n;
        send(moduleAddr, 8'h03, 8'h00, 8'h00, 32'h0, 8'h00);
        @(posedge clk_sys);
        host.slow = 1'b1;
        host.fill(f, n);
        // 32 stored words plus the output register
        chk(n, 33);
        exec(8'h64, 32'h0);
        expectReply(8'h64, 8'h03, 32'h0);
        for (int k = n; k < 36; k++) rest.push_back(f[k % 9]);
        host.sendFrame(rest);
        repeat (80) @(posedge clk_sys);
        chk(nDrop, 5);
        chk(host.got.size(), 0);
        host.slow = 1'b0;
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        chk({rxReady, busDriveEn_ff, txValid_ff}, 3'b100);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        t_codes;
        t_badsum;
        t_foreign;
        t_can;
        t_fifo;
        results;
    end
endmodule // cmd_frame_interp_bench

// >>> cmd_frame_interp_properties.sv
`timescale 1ns/100ps
module cmd_frame_checker (
    input wire logic       clk_sys,
    input wire logic       arst_n,
    input wire logic       cmdValid_ff,
    input wire logic [7:0] txData_ff,
    input wire logic       txValid_ff,
    input wire logic       txReady,
    input wire logic       txFirst_ff,
    input wire logic       txLast_ff,
    input wire logic       busDriveEn_ff,
    input wire logic       frameDropped_ff,
    input wire logic       checksumError_ff
);
    logic owed_ff;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // a reply is owed from an accepted command or a checksum error until its last byte leaves
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            owed_ff <= 1'b0;
        else if (cmdValid_ff || checksumError_ff)
            owed_ff <= 1'b1;
        else if (txValid_ff && txReady && txLast_ff)
            owed_ff <= 1'b0;
    end
    chk_tx_owns_bus: assert property (txValid_ff |-> busDriveEn_ff)
        else $error("byte offered without bus drive");
    chk_bus_release: assert property (txValid_ff && txReady && txLast_ff |=> !txValid_ff && !busDriveEn_ff)
        else $error("bus kept after last reply byte");
    chk_reply_owed: assert property ($rose(busDriveEn_ff) |-> owed_ff || checksumError_ff || $past(checksumError_ff))
        else $error("bus taken with no command pending");
    chk_first_byte: assert property ($rose(busDriveEn_ff) |-> txValid_ff && txFirst_ff)
        else $error("reply did not start with first byte");
    chk_single_cmd: assert property (cmdValid_ff |-> !owed_ff ##1 !cmdValid_ff)
        else $error("command issued while reply owed");
    chk_byte_hold: assert property (txValid_ff && !txReady |=> txValid_ff && $stable(txData_ff) && $stable(txLast_ff))
        else $error("reply byte changed while stalled");
    chk_drop_quiet: assert property (frameDropped_ff |-> !cmdValid_ff && !busDriveEn_ff ##1 !busDriveEn_ff [*8])
        else $error("dropped frame caused activity");
    chk_sum_reply: assert property (checksumError_ff |-> !cmdValid_ff ##[0:8] busDriveEn_ff)
        else $error("bad checksum not answered or executed");
endmodule // cmd_frame_checker

bind cmd_frame_interp cmd_frame_checker chk (.clk_sys, .arst_n, .cmdValid_ff, .txData_ff, .txValid_ff, .txReady,
    .txFirst_ff, .txLast_ff, .busDriveEn_ff, .frameDropped_ff, .checksumError_ff);

// >>> cmd_frame_regs.vh
`ifndef CMD_FRAME_REGS_VH
`define CMD_FRAME_REGS_VH

// frame lengths in bytes
`define CF_CORE_LEN          4'h7
`define CF_SERIAL_CMD_LEN    4'h9
`define CF_SERIAL_REPLY_LEN  4'h9
`define CF_CAN_REPLY_LEN     4'h6

// byte positions inside a serial frame
`define CF_POS_ADDR          4'h0
`define CF_POS_CODE          4'h1
`define CF_POS_TYPE          4'h2
`define CF_POS_MOTOR         4'h3
`define CF_POS_VALUE_MSB     4'h4
`define CF_POS_VALUE_LSB     4'h7
`define CF_POS_CHECKSUM      4'h8

// byte positions inside a serial reply
`define CF_RPOS_REPLY_ADDR   4'h0
`define CF_RPOS_MODULE_ADDR  4'h1
`define CF_RPOS_STATUS       4'h2
`define CF_RPOS_CODE         4'h3
`define CF_RPOS_VALUE_MSB    4'h4
`define CF_RPOS_VALUE_LSB    4'h7
`define CF_RPOS_CHECKSUM     4'h8

// offset of the first byte that is still present on CAN
`define CF_CAN_CMD_SKIP      4'h1
`define CF_CAN_REPLY_SKIP    4'h2

// reply status codes
`define CF_ST_OK             8'h64
`define CF_ST_STORED         8'h65
`define CF_ST_BAD_CHECKSUM   8'h01
`define CF_ST_BAD_COMMAND    8'h02
`define CF_ST_BAD_TYPE       8'h03
`define CF_ST_BAD_VALUE      8'h04
`define CF_ST_CFG_LOCKED     8'h05
`define CF_ST_NOT_AVAILABLE  8'h06

// receive buffer shape
`define CF_FIFO_WIDTH        8
`define CF_FIFO_DEPTH        32
`define CF_FIFO_AW           5

`endif

// >>> host_model.sv
`timescale 1ns/100ps
module host_model (
    input  wire logic       clk_sys,
    input  wire logic       rxReady,
    output logic      [7:0] rxData,
    output logic            rxValid,
    input  wire logic [7:0] txData_ff,
    input  wire logic       txValid_ff,
    output logic            txReady
);
    logic [7:0] got[$];
    logic       slow = 1'b0;
    initial begin
        rxData = 8'h00;
        rxValid = 1'b0;
        txReady = 1'b0;
    end
    // each byte held until taken; released data shows the inverse
    task sendFrame(input logic [7:0] q[$]);
        foreach (q[i]) begin
            rxValid <= 1'b1;
            rxData <= q[i];
            @(posedge clk_sys);
            while (rxReady !== 1'b1) @(posedge clk_sys);
        end
        rxValid <= 1'b0;
        rxData <= ~q[q.size()-1];
    endtask
    // pushes bytes of a 9-byte frame until refused for four edges
    task fill(input logic [7:0] f[9], output int n);
        int idle;
        n = 0;
        idle = 0;
        while (idle < 4) begin
            rxValid <= 1'b1;
            rxData <= f[n % 9];
            @(posedge clk_sys);
            if (rxReady === 1'b1) begin
                n++;
                idle = 0;
            end else idle++;
        end
        rxValid <= 1'b0;
        rxData <= ~f[(n + 8) % 9];
    endtask
    // collects reply bytes, stalling on alternate cycles when slow
    always @(posedge clk_sys) begin
        if (txValid_ff && txReady)
            got.push_back(txData_ff);
        txReady <= !slow || !txReady;
    end
endmodule // host_model
